// file: hw/axis_trim_pkg.sv
// shared constants for the axis user trim register bank
package axis_trim_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] third_axis_bias_trim_addr = 8'h35;
  localparam logic [7:0] first_axis_gain_trim_addr = 8'h36;
  localparam logic [7:0] second_axis_gain_trim_addr = 8'h37;
  localparam logic [7:0] third_axis_gain_trim_addr = 8'h38;
  localparam logic [7:0] trim_reset_value = 8'h00;
  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int bias_width = 5;
  localparam int gain_width = 6;
  localparam int bias_sign_bit = 4;
  localparam int gain_sign_bit = 5;
  // ****************************************************************
  // shared adjustment range, in trim counts
  // ****************************************************************
  localparam int combined_width = 8;
  localparam logic signed [7:0] bias_range_max = 8'sh0f;
  localparam logic signed [7:0] bias_range_min = -8'sh10;
  localparam logic signed [7:0] gain_range_max = 8'sh1f;
  localparam logic signed [7:0] gain_range_min = -8'sh20;
endpackage : axis_trim_pkg

// file: hw/axis_user_trim_regs.sv
// user trim register bank with factory trim combination
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module axis_user_trim_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [4:0] factory_third_axis_bias,
  input wire logic [5:0] factory_first_axis_gain,
  input wire logic [5:0] factory_second_axis_gain,
  input wire logic [5:0] factory_third_axis_gain,
  output logic [7:0] third_axis_bias_total,
  output logic [7:0] first_axis_gain_total,
  output logic [7:0] second_axis_gain_total,
  output logic [7:0] third_axis_gain_total
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [4:0] bias_z;
    logic [5:0] first_axis_gain_value;
    logic [5:0] second_axis_gain_value;
    logic [5:0] third_axis_gain_value;
    logic [7:0] rdata;
    logic [7:0] bias_tot;
    logic [7:0] gain_tot_0;
    logic [7:0] gain_tot_1;
    logic [7:0] gain_tot_2;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // factory trims are static fuses on this clock, no sync needed
  // clipping rather than wrapping keeps a big sum from flipping sign
  function automatic logic [7:0] sat_add(input logic signed [7:0] a,
                                         input logic signed [7:0] b,
                                         input logic signed [7:0] lo,
                                         input logic signed [7:0] hi);
    logic signed [8:0] s;
    s = 9'(a) + 9'(b);
    if (s > 9'(hi)) begin
      sat_add = hi;
    end else if (s < 9'(lo)) begin
      sat_add = lo;
    end else begin
      sat_add = s[7:0];
    end
  endfunction : sat_add

  function automatic logic [7:0] sx5(input logic [4:0] v);
    sx5 = {{3{v[axis_trim_pkg::bias_sign_bit]}}, v};
  endfunction : sx5

  function automatic logic [7:0] sx6(input logic [5:0] v);
    sx6 = {{2{v[axis_trim_pkg::gain_sign_bit]}}, v};
  endfunction : sx6

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    // only the low field bits are kept, so reserved bits read zero
    if (wr_en) begin
      case (addr)
        axis_trim_pkg::third_axis_bias_trim_addr: begin
          nxt_st.bias_z = wdata[4:0];
        end
        axis_trim_pkg::first_axis_gain_trim_addr: begin
          nxt_st.first_axis_gain_value = wdata[5:0];
        end
        axis_trim_pkg::second_axis_gain_trim_addr: begin
          nxt_st.second_axis_gain_value = wdata[5:0];
        end
        axis_trim_pkg::third_axis_gain_trim_addr: begin
          nxt_st.third_axis_gain_value = wdata[5:0];
        end
        default: begin
        end
      endcase
    end
    // read data stands only in the cycle after the strobe
    nxt_st.rdata = 8'h00;
    if (rd_en) begin
      case (addr)
        axis_trim_pkg::third_axis_bias_trim_addr: begin
          nxt_st.rdata = {3'h0, st_ff.bias_z};
        end
        axis_trim_pkg::first_axis_gain_trim_addr: begin
          nxt_st.rdata = {2'h0, st_ff.first_axis_gain_value};
        end
        axis_trim_pkg::second_axis_gain_trim_addr: begin
          nxt_st.rdata = {2'h0, st_ff.second_axis_gain_value};
        end
        axis_trim_pkg::third_axis_gain_trim_addr: begin
          nxt_st.rdata = {2'h0, st_ff.third_axis_gain_value};
        end
        default: begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end
    // totals follow stored trims one cycle later
    nxt_st.bias_tot = sat_add(sx5(st_ff.bias_z), sx5(factory_third_axis_bias),
      axis_trim_pkg::bias_range_min, axis_trim_pkg::bias_range_max);
    nxt_st.gain_tot_0 = sat_add(sx6(st_ff.first_axis_gain_value),
      sx6(factory_first_axis_gain), axis_trim_pkg::gain_range_min,
      axis_trim_pkg::gain_range_max);
    nxt_st.gain_tot_1 = sat_add(sx6(st_ff.second_axis_gain_value),
      sx6(factory_second_axis_gain), axis_trim_pkg::gain_range_min,
      axis_trim_pkg::gain_range_max);
    nxt_st.gain_tot_2 = sat_add(sx6(st_ff.third_axis_gain_value),
      sx6(factory_third_axis_gain), axis_trim_pkg::gain_range_min,
      axis_trim_pkg::gain_range_max);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign third_axis_bias_total = st_ff.bias_tot;
  assign first_axis_gain_total = st_ff.gain_tot_0;
  assign second_axis_gain_total = st_ff.gain_tot_1;
  assign third_axis_gain_total = st_ff.gain_tot_2;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a write followed at once by a read of the same register
  bias_write_a: assert property (wr_en &&
    addr == axis_trim_pkg::third_axis_bias_trim_addr ##1 rd_en &&
    addr == axis_trim_pkg::third_axis_bias_trim_addr |=>
    rdata == ($past(wdata, 2) & 8'h1f))
    else $error("bias trim readback wrong");
  gain_x_write_a: assert property (wr_en &&
    addr == axis_trim_pkg::first_axis_gain_trim_addr ##1 rd_en &&
    addr == axis_trim_pkg::first_axis_gain_trim_addr |=>
    rdata == ($past(wdata, 2) & 8'h3f))
    else $error("first gain readback wrong");
  gain_y_write_a: assert property (wr_en &&
    addr == axis_trim_pkg::second_axis_gain_trim_addr ##1 rd_en &&
    addr == axis_trim_pkg::second_axis_gain_trim_addr |=>
    rdata == ($past(wdata, 2) & 8'h3f))
    else $error("second gain readback wrong");
  gain_z_write_a: assert property (wr_en &&
    addr == axis_trim_pkg::third_axis_gain_trim_addr ##1 rd_en &&
    addr == axis_trim_pkg::third_axis_gain_trim_addr |=>
    rdata == ($past(wdata, 2) & 8'h3f))
    else $error("third gain readback wrong");
  // the sum is held to the field's own range, so a unit whose factory
  // trim sits near an edge leaves the user less room
  bias_range_a: assert property (
    $signed(third_axis_bias_total) <= axis_trim_pkg::bias_range_max &&
    $signed(third_axis_bias_total) >= axis_trim_pkg::bias_range_min)
    else $error("bias total out of range");
  gain_range_a: assert property (
    $signed(first_axis_gain_total) <= axis_trim_pkg::gain_range_max &&
    $signed(first_axis_gain_total) >= axis_trim_pkg::gain_range_min)
    else $error("gain total out of range");
  gain_y_range_a: assert property (
    $signed(second_axis_gain_total) <= axis_trim_pkg::gain_range_max &&
    $signed(second_axis_gain_total) >= axis_trim_pkg::gain_range_min)
    else $error("second gain total out of range");
  gain_z_range_a: assert property (
    $signed(third_axis_gain_total) <= axis_trim_pkg::gain_range_max &&
    $signed(third_axis_gain_total) >= axis_trim_pkg::gain_range_min)
    else $error("third gain total out of range");
  reserved_zero_a: assert property (rd_en && addr ==
    axis_trim_pkg::third_axis_bias_trim_addr |=> rdata[7:5] == 3'h0)
    else $error("reserved bits not zero");
  gain_reserved_a: assert property (rd_en && (
    addr == axis_trim_pkg::first_axis_gain_trim_addr ||
    addr == axis_trim_pkg::second_axis_gain_trim_addr ||
    addr == axis_trim_pkg::third_axis_gain_trim_addr) |=> rdata[7:6] == 2'h0)
    else $error("gain reserved bits not zero");
  unmapped_read_a: assert property (rd_en &&
    (addr < axis_trim_pkg::third_axis_bias_trim_addr ||
    addr > axis_trim_pkg::third_axis_gain_trim_addr) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  idle_read_a: assert property (!rd_en |=> rdata == 8'h00)
    else $error("read data held without strobe");
  // bias and first gain totals stand while nothing that feeds them moves
  bias_hold_a: assert property (!wr_en ##1
    $stable(factory_third_axis_bias) |=> $stable(third_axis_bias_total))
    else $error("bias total moved without cause");
  gain_hold_a: assert property (!wr_en ##1
    $stable(factory_first_axis_gain) |=> $stable(first_axis_gain_total))
    else $error("first gain total moved without cause");

  // main scenarios the bench should reach
  bias_wr_c: cover property (wr_en &&
    addr == axis_trim_pkg::third_axis_bias_trim_addr);
  gain_rd_c: cover property (rd_en &&
    addr == axis_trim_pkg::first_axis_gain_trim_addr);
  sat_hi_c: cover property (first_axis_gain_total ==
    axis_trim_pkg::gain_range_max);
  sat_lo_c: cover property (third_axis_bias_total ==
    axis_trim_pkg::bias_range_min);
  wr_rd_c: cover property (wr_en ##1 rd_en);
endmodule : axis_user_trim_regs
`default_nettype wire

// file: verif/axis_user_trim_regs_bench.sv
// self-checking bench for the axis user trim register bank
`timescale 1ns/1ps
`default_nettype none
module axis_user_trim_regs_bench;
  logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, pend = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [4:0] fb = 5'h00;
  logic [5:0] fg [3] = '{default: 6'h00};
  logic [7:0] tot [4];
  logic [7:0] u [4] = '{default: 8'h00};
  logic [7:0] exp_q [$];
  int failures = 0, samples_checked = 0, seed = 16389;
  always #12.5 clk = ~clk;
  axis_user_trim_regs axis_user_trim_regs_inst (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .factory_third_axis_bias(fb), .factory_first_axis_gain(fg[0]),
    .factory_second_axis_gain(fg[1]), .factory_third_axis_gain(fg[2]),
    .third_axis_bias_total(tot[0]), .first_axis_gain_total(tot[1]),
    .second_axis_gain_total(tot[2]), .third_axis_gain_total(tot[3])
  );
  // ****************************************************************
  // bus driving and comparison
  // ****************************************************************
  task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  // every call sets all bus signals once, so back to back calls never clash
  task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask : bus
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  function automatic logic [7:0] sat(int v, int lo, int hi);
    return (v > hi) ? hi[7:0] : (v < lo) ? lo[7:0] : v[7:0];
  endfunction : sat
  // totals settle two edges after the last write
  task automatic chk_tot();
    int v;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge clk);
    v = $signed(u[0][4:0]) + $signed(fb);
    cmp("bias_total", sat(v, axis_trim_pkg::bias_range_min,
      axis_trim_pkg::bias_range_max), tot[0]);
    for (int i = 1; i < 4; i++) begin
      v = $signed(u[i][5:0]) + $signed(fg[i-1]);
      cmp("gain_total", sat(v, axis_trim_pkg::gain_range_min,
        axis_trim_pkg::gain_range_max), tot[i]);
    end
    @(posedge clk);
  endtask : chk_tot
  // read data stand only in the cycle after the strobe
  always @(posedge clk) pend <= rd_en;
  always @(negedge clk) begin
    if (pend) cmp("rdata", exp_q.pop_front(), rdata);
  end
  task automatic print_verdict();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd(8'h35 + 8'(i), 8'h00);
    chk_tot();
    $display("reset values done");
    for (int k = 0; k < 20; k++) begin
      fb <= 5'($random(seed));
      for (int i = 0; i < 3; i++) fg[i] <= 6'($random(seed));
      for (int i = 0; i < 4; i++) begin
        u[i] = 8'($random(seed));
        bus(1'b1, 1'b0, 8'h35 + 8'(i), u[i]);
        rd(8'h35 + 8'(i), u[i] & (i == 0 ? 8'h1f : 8'h3f));
      end
      bus(1'b1, 1'b0, 8'h39, 8'($random(seed)));
      rd(8'h35, {3'h0, u[0][4:0]});
      for (int i = 1; i < 4; i++) rd(8'h35 + 8'(i), {2'h0, u[i][5:0]});
      rd(8'h39, 8'h00);
      chk_tot();
      $display("round %0d done", k);
    end
    rst_n <= 1'b0;
    u = '{default: 8'h00};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd(8'h35 + 8'(i), 8'h00);
    chk_tot();
    $display("mid-run reset done");
    print_verdict();
  end
  // the run needs well under a thousand cycles
  initial begin
    #50000;
    failures++;
    print_verdict();
  end
endmodule : axis_user_trim_regs_bench
`default_nettype wire
